/* File: rtl/tsc_defs.svh */
// Constants of the temperature sensor serial control block.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// ==========================================================
// Bus addresses
`define TSC_ADDR_HI        4'h9
`define TSC_ARA_ADDR       7'h0C

// ==========================================================
// Pointer values
`define TSC_PTR_TEMP       2'h0
`define TSC_PTR_CFG        2'h1
`define TSC_PTR_UPPER      2'h2
`define TSC_PTR_LOWER      2'h3

// ==========================================================
// Reset values and configuration fields
`define TSC_CFG_RST        8'h40
`define TSC_UPPER_RST      8'h7F
`define TSC_LOWER_RST      8'h80
`define TSC_CFG_KEEP       8'hF3
`define TSC_CFG_PD         7
`define TSC_CFG_ALERT_DIS  5
`define TSC_CFG_POL        4
`define TSC_CFG_ALERT_CLR  3
`define TSC_CFG_ONESHOT    2

// ==========================================================
// Timing
`define TSC_CLK_NS         4
`define TSC_WAKE_NS        4000
`define TSC_WAKE_CYC       ((`TSC_WAKE_NS + `TSC_CLK_NS - 1) / `TSC_CLK_NS)
`define TSC_PERIOD_MS      800
`define TSC_PERIOD_CYC     (`TSC_PERIOD_MS * 1000000 / `TSC_CLK_NS)

`endif

/* File: rtl/tsc_pkg.sv */
// Types of the temperature sensor serial control block.
// Needs nothing from its surroundings.
package tsc_pkg;

    // ==========================================================
    // Serial slave states
    typedef enum logic [6:0] {
        SER_IDLE    = 7'b0000001,
        SER_ADDR    = 7'b0000010,
        SER_ADDR_AK = 7'b0000100,
        SER_WR      = 7'b0001000,
        SER_WR_AK   = 7'b0010000,
        SER_RD      = 7'b0100000,
        SER_RD_AK   = 7'b1000000
    } tsc_ser_type;

    // ==========================================================
    // Conversion scheduler states
    typedef enum logic [2:0] {
        CNV_SLEEP = 3'b001,
        CNV_WAKE  = 3'b010,
        CNV_RUN   = 3'b100
    } tsc_cnv_type;

endpackage : tsc_pkg

/* File: rtl/tsc_sync.sv */
// Two-stage synchroniser for pins entering the system clock domain.
// Assumes inputs are asynchronous levels.
`timescale 1ns/1ps
module tsc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,  // System clock
    input  wire logic             rst_n,    // Async reset, active low
    input  wire logic [WIDTH-1:0] async_in, // Pin levels
    input  wire logic [WIDTH-1:0] rst_val,  // Unused-safe idle levels
    output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);
    logic [WIDTH-1:0] meta_ff;

    // ==========================================================
    // Stage one is read only by stage two
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff  <= '1;
            sync_out <= '1;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : tsc_sync

/* File: rtl/tsc_serial_ctrl.sv */
// Two-wire slave, registers, alert and conversion scheduling of a
// digital temperature sensor. Assumes SCL, SDA and the address
// strap arrive asynchronously; the converter shares sys_clk.
//
// Operation
// - Answer address 1001 plus strap-selected bits
// - Detect SDA fall while SCL high
// - Shift eight bits, address then direction
// - Acknowledge own address, else stay idle
// - Direction 0 writes, 1 reads
// - Nine clocks per byte, receiver acknowledges
// - SDA changes on SCL low; rise-high is STOP
// - Direction fixed until new START
// - Single-byte write loads pointer only
// - Second byte pointer, third byte register data
// - Pointer persists across reads
// - Temperature reads two bytes, others one
// - D4 polarity, low default; D5 disables alert
// - Acknowledge alert response only while alerting
// - Alert sets above upper, clears low or D3
// - Reset pointer temp, limits 7F/80, config 40
// - Convert every 800 ms, sleep between
// - D2 write converts now, schedule resumes
// - Drop result if bus access active
// - D7 stops periodic conversions, full power-down
// - One-shot wakes 4 us, converts, sleeps
// - 10-bit result, bytes: upper eight, rest+flags
// - Limit flags clear on second byte read
// - D3 and D2 read back zero
// - Limits are signed 8-bit whole degrees
`include "tsc_defs.svh"
`timescale 1ns/1ps
module tsc_serial_ctrl
    import tsc_pkg::*;
#(
    parameter int       PERIOD_CYC = `TSC_PERIOD_CYC, // Cycles between conversions
    parameter int       WAKE_CYC   = `TSC_WAKE_CYC,   // Converter power-up cycles
    parameter bit [2:0] ADDR_GND   = 3'h0,            // Low bits, strap tied low
    parameter bit [2:0] ADDR_VDD   = 3'h2,            // Low bits, strap tied high
    parameter bit [2:0] ADDR_FLT   = 3'h1             // Low bits, strap floating
) (
    input  wire logic       sys_clk,                  // System clock, 250 MHz
    input  wire logic       rst_n,                    // Async reset, active low
    input  wire logic       scl_in,                   // Bus clock pin
    input  wire logic       sda_in,                   // Bus data pin level
    output logic            sda_out,                  // Bus data drive value
    output logic            sda_oe,                   // Bus data pull-down enable
    input  wire logic       address_select_pin_low,   // Strap tied low
    input  wire logic       address_select_pin_high,  // Strap tied high
    output logic            alert_out,                // Alert drive value
    output logic            alert_oe,                 // Alert pull-down enable
    output logic            conv_power_on,            // Converter powered
    output logic            conv_start,               // Start pulse to converter
    input  wire logic       conv_done,                // Conversion finished pulse
    input  wire logic [9:0] conv_result,              // Two's complement result
    output logic            full_power_down           // Full power-down state
);
    // ==========================================================
    // Declarations
    logic [3:0]  pins_sync;
    logic        scl_prev_ff;
    logic        sda_prev_ff;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;
    logic        strap_done_ff;
    logic [1:0]  strap_cnt_ff;
    logic [6:0]  own_addr_ff;
    tsc_ser_type ser_ff;
    logic [3:0]  bitcnt_ff;
    logic [7:0]  rx_ff;
    logic [7:0]  tx_ff;
    logic        sda_oe_ff;
    logic        busy_ff;
    logic        ara_ff;
    logic [1:0]  wr_idx_ff;
    logic        rd_idx_ff;
    logic [1:0]  ptr_ff;
    logic [7:0]  cfg_ff;
    logic [7:0]  upper_ff;
    logic [7:0]  lower_ff;
    logic [9:0]  temp_ff;
    logic        alert_ff;
    logic        hi_flag_ff;
    logic        lo_flag_ff;
    logic        alert_oe_ff;
    logic        cfg_wr;
    logic        data_wr;
    logic        byte_done;
    logic        addr_match;
    logic        rd_load;
    logic        flag_rd;
    logic [7:0]  nxt_tx;
    logic        over_lim;
    logic        under_lim;
    logic        alert_on;
    logic        temp_load;
    tsc_cnv_type cnv_ff;
    logic [31:0] period_cnt_ff;
    logic [15:0] wake_cnt_ff;
    logic        oneshot_ff;
    logic        tick;

    // ==========================================================
    // Pin synchronisers: SCL, SDA and both strap levels
    tsc_sync #(.WIDTH(4)) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({address_select_pin_high, address_select_pin_low, sda_in, scl_in}),
        .rst_val  (4'hF),
        .sync_out (pins_sync)
    );

    // Previous levels for edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_prev_ff <= pins_sync[0];
            sda_prev_ff <= pins_sync[1];
        end
    end

    assign scl_rise  = pins_sync[0] & ~scl_prev_ff;
    assign scl_fall  = ~pins_sync[0] & scl_prev_ff;
    assign bus_start = pins_sync[0] & scl_prev_ff & sda_prev_ff & ~pins_sync[1];
    assign bus_stop  = pins_sync[0] & scl_prev_ff & ~sda_prev_ff & pins_sync[1];

    // ==========================================================
    // Strap capture once, after the synchroniser has flushed its reset levels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_ff  <= 2'h0;
            strap_done_ff <= 1'b0;
            own_addr_ff   <= 7'h00;
        end else if (!strap_done_ff) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == 2'h2) begin
                strap_done_ff <= 1'b1;
                if (pins_sync[2])
                    own_addr_ff <= {`TSC_ADDR_HI, ADDR_GND};
                else if (pins_sync[3])
                    own_addr_ff <= {`TSC_ADDR_HI, ADDR_VDD};
                else
                    own_addr_ff <= {`TSC_ADDR_HI, ADDR_FLT};
            end
        end
    end

    // ==========================================================
    // Serial decode helpers
    assign byte_done  = scl_fall && (bitcnt_ff == 4'h8);
    assign addr_match = strap_done_ff && (rx_ff[7:1] == own_addr_ff);
    assign alert_on   = alert_ff & ~cfg_ff[`TSC_CFG_ALERT_DIS];
    assign cfg_wr     = data_wr && (ptr_ff == `TSC_PTR_CFG);
    assign data_wr    = (ser_ff == SER_WR) && byte_done && (wr_idx_ff == 2'h1);
    assign rd_load    = scl_fall && ((ser_ff == SER_ADDR_AK && rx_ff[0])
                                  || (ser_ff == SER_RD_AK));
    assign flag_rd    = rd_load && !ara_ff && ptr_ff == `TSC_PTR_TEMP && rd_idx_ff;

    // Byte to send next; pointer picks the register
    always_comb begin
        nxt_tx = 8'h00;
        if (ara_ff)
            nxt_tx = {own_addr_ff, 1'b0};
        else begin
            case (ptr_ff)
                `TSC_PTR_TEMP:  nxt_tx = rd_idx_ff ?
                                    {temp_ff[1:0], alert_on, hi_flag_ff,
                                     lo_flag_ff, 3'h0} : temp_ff[9:2];
                `TSC_PTR_CFG:   nxt_tx = cfg_ff;
                `TSC_PTR_UPPER: nxt_tx = upper_ff;
                `TSC_PTR_LOWER: nxt_tx = lower_ff;
                default:        nxt_tx = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Serial slave state, bit count and shifters
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_ff    <= SER_IDLE;
            bitcnt_ff <= 4'h0;
            rx_ff     <= 8'h00;
            tx_ff     <= 8'hFF;
            sda_oe_ff <= 1'b0;
            ara_ff    <= 1'b0;
        end else if (bus_start) begin
            ser_ff    <= SER_ADDR;
            bitcnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
            ara_ff    <= 1'b0;
        end else if (bus_stop) begin
            ser_ff    <= SER_IDLE;
            sda_oe_ff <= 1'b0;
        end else begin
            case (ser_ff)
                SER_ADDR, SER_WR: begin
                    if (scl_rise) begin
                        rx_ff     <= {rx_ff[6:0], pins_sync[1]};
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                    end else if (byte_done) begin
                        bitcnt_ff <= 4'h0;
                        if (ser_ff == SER_WR) begin
                            ser_ff    <= SER_WR_AK;
                            sda_oe_ff <= 1'b1;
                        end else if (addr_match) begin
                            ser_ff    <= SER_ADDR_AK;
                            sda_oe_ff <= 1'b1;
                        end else if (rx_ff == {`TSC_ARA_ADDR, 1'b1} && alert_on) begin
                            ser_ff    <= SER_ADDR_AK;
                            sda_oe_ff <= 1'b1;
                            ara_ff    <= 1'b1;
                        end else begin
                            ser_ff <= SER_IDLE;
                        end
                    end
                end
                SER_ADDR_AK: begin
                    if (scl_fall) begin
                        if (rx_ff[0]) begin
                            ser_ff    <= SER_RD;
                            tx_ff     <= nxt_tx;
                            sda_oe_ff <= ~nxt_tx[7];
                        end else begin
                            ser_ff    <= SER_WR;
                            sda_oe_ff <= 1'b0;
                        end
                    end
                end
                SER_WR_AK: begin
                    if (scl_fall) begin
                        ser_ff    <= SER_WR;
                        sda_oe_ff <= 1'b0;
                    end
                end
                SER_RD: begin
                    if (scl_rise) begin
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                        // Released a one but bus is low: arbitration lost
                        if (tx_ff[7] && !pins_sync[1])
                            ser_ff <= SER_IDLE;
                    end else if (byte_done) begin
                        bitcnt_ff <= 4'h0;
                        ser_ff    <= SER_RD_AK;
                        sda_oe_ff <= 1'b0;
                    end else if (scl_fall) begin
                        tx_ff     <= {tx_ff[6:0], 1'b1};
                        sda_oe_ff <= ~tx_ff[6];
                    end
                end
                SER_RD_AK: begin
                    if (scl_rise && pins_sync[1])
                        ser_ff <= SER_IDLE;
                    else if (scl_fall) begin
                        ser_ff    <= SER_RD;
                        tx_ff     <= nxt_tx;
                        sda_oe_ff <= ~nxt_tx[7];
                    end
                end
                SER_IDLE: begin
                    sda_oe_ff <= 1'b0;
                end
                default: begin
                    ser_ff    <= SER_IDLE;
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Access busy from START to STOP, which holds back results
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            busy_ff <= 1'b0;
        else if (bus_start)
            busy_ff <= 1'b1;
        else if (bus_stop)
            busy_ff <= 1'b0;
    end

    // Byte indices within a write and within a read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx_ff <= 2'h0;
            rd_idx_ff <= 1'b0;
        end else if (bus_start) begin
            wr_idx_ff <= 2'h0;
            rd_idx_ff <= 1'b0;
        end else begin
            if (ser_ff == SER_WR && byte_done && wr_idx_ff != 2'h2)
                wr_idx_ff <= wr_idx_ff + 2'h1;
            if (rd_load)
                rd_idx_ff <= ~rd_idx_ff;
        end
    end

    // ==========================================================
    // Pointer and data registers; bytes past the third are acked, not stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_ff   <= `TSC_PTR_TEMP;
            cfg_ff   <= `TSC_CFG_RST;
            upper_ff <= `TSC_UPPER_RST;
            lower_ff <= `TSC_LOWER_RST;
        end else if (ser_ff == SER_WR && byte_done) begin
            if (wr_idx_ff == 2'h0)
                ptr_ff <= rx_ff[1:0];
            else if (wr_idx_ff == 2'h1) begin
                case (ptr_ff)
                    `TSC_PTR_CFG:   cfg_ff   <= rx_ff & `TSC_CFG_KEEP;
                    `TSC_PTR_UPPER: upper_ff <= rx_ff;
                    `TSC_PTR_LOWER: lower_ff <= rx_ff;
                    default:        cfg_ff   <= cfg_ff;
                endcase
            end
        end
    end

    // ==========================================================
    // Limit compare on whole degrees of the result
    assign over_lim  = $signed(temp_ff[9:2]) > $signed(upper_ff);
    assign under_lim = $signed(temp_ff[9:2]) < $signed(lower_ff);

    // Flags: a set in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_flag_ff <= 1'b0;
            lo_flag_ff <= 1'b0;
        end else begin
            hi_flag_ff <= over_lim  | (hi_flag_ff & ~flag_rd);
            lo_flag_ff <= under_lim | (lo_flag_ff & ~flag_rd);
        end
    end

    // Alert latch sets only on a fresh result, so a D3 reset waits for the next one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            alert_ff <= 1'b0;
        else if (temp_load && $signed(conv_result[9:2]) > $signed(upper_ff))
            alert_ff <= 1'b1;
        else if (under_lim || (cfg_wr && rx_ff[`TSC_CFG_ALERT_CLR]))
            alert_ff <= 1'b0;
    end

    // Open drain: pull low when asserted low-active, or idle high-active
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            alert_oe_ff <= 1'b0;
        else
            alert_oe_ff <= alert_on ^ cfg_ff[`TSC_CFG_POL];
    end

    // ==========================================================
    // Result capture, refused while a bus access is open
    assign temp_load = conv_done && !busy_ff && cnv_ff == CNV_RUN;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            temp_ff <= 10'h000;
        else if (temp_load)
            temp_ff <= conv_result;
    end

    // ==========================================================
    // Conversion scheduling
    assign tick = (period_cnt_ff == 32'(PERIOD_CYC - 1));

    // One-shot request held until the scheduler takes it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            oneshot_ff <= 1'b0;
        else if (cfg_wr && rx_ff[`TSC_CFG_ONESHOT])
            oneshot_ff <= 1'b1;
        else if (cnv_ff == CNV_SLEEP)
            oneshot_ff <= 1'b0;
    end

    // Period counter; restarts on a one-shot so the schedule resumes from it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            period_cnt_ff <= 32'h0000_0000;
        else if (cfg_ff[`TSC_CFG_PD] || tick || (oneshot_ff && cnv_ff == CNV_SLEEP))
            period_cnt_ff <= 32'h0000_0000;
        else
            period_cnt_ff <= period_cnt_ff + 32'h0000_0001;
    end

    // Sleep, power-up wait, convert
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnv_ff      <= CNV_SLEEP;
            wake_cnt_ff <= 16'h0000;
        end else begin
            case (cnv_ff)
                CNV_SLEEP: begin
                    wake_cnt_ff <= 16'h0000;
                    if (oneshot_ff || (tick && !cfg_ff[`TSC_CFG_PD]))
                        cnv_ff <= CNV_WAKE;
                end
                CNV_WAKE: begin
                    wake_cnt_ff <= wake_cnt_ff + 16'h0001;
                    if (wake_cnt_ff == 16'(WAKE_CYC - 1))
                        cnv_ff <= CNV_RUN;
                end
                CNV_RUN: begin
                    if (conv_done)
                        cnv_ff <= CNV_SLEEP;
                end
                default: cnv_ff <= CNV_SLEEP;
            endcase
        end
    end

    // ==========================================================
    // Outputs
    assign sda_out         = 1'b0;
    assign sda_oe          = sda_oe_ff;
    assign alert_out       = 1'b0;
    assign alert_oe        = alert_oe_ff;
    assign conv_power_on   = (cnv_ff != CNV_SLEEP);
    assign conv_start      = (cnv_ff == CNV_WAKE) && (wake_cnt_ff == 16'(WAKE_CYC - 1));
    assign full_power_down = cfg_ff[`TSC_CFG_PD];
endmodule : tsc_serial_ctrl

/* File: sim/tsc_serial_ctrl_props.sv */
// Port checker for the serial control block.
// Assumes binding onto tsc_serial_ctrl with WAKE_CYC passed on.
`timescale 1ns/1ps
module tsc_serial_ctrl_props #(
    parameter int WAKE_CYC = 10          // Converter power-up cycles
) (
    input wire logic sys_clk,            // System clock
    input wire logic rst_n,              // Async reset, active low
    input wire logic scl_in,             // Bus clock pin
    input wire logic sda_out,            // Data drive value
    input wire logic sda_oe,             // Data pull-down
    input wire logic conv_power_on,      // Converter powered
    input wire logic conv_start,         // Start pulse
    input wire logic conv_done,          // Done pulse
    input wire logic alert_out,          // Alert drive value
    input wire logic full_power_down     // Power-down state
);
    localparam int WMAX = WAKE_CYC + 2;
    // ==========================================
    // Checks; the pin is only ever pulled low
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_sda_hold: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda drive moved while clock high");
    a_drive_zero: assert property (!sda_out)
        else $error("sda drive value not low");
    a_alert_zero: assert property (!alert_out)
        else $error("alert drive value not low");
    a_wake_wait: assert property ($rose(conv_power_on) |-> !conv_start [*8])
        else $error("start before power-up wait");
    a_wake_bound: assert property ($rose(conv_power_on) |-> ##[1:WMAX] conv_start)
        else $error("start missing after power-up");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    a_start_powered: assert property (conv_start |-> conv_power_on)
        else $error("start while unpowered");
    a_done_sleep: assert property (conv_done && conv_power_on |=> !conv_power_on)
        else $error("converter stays powered after done");
    a_pd_write: assert property ($changed(full_power_down) |-> !scl_in)
        else $error("power-down moved outside a write");
endmodule : tsc_serial_ctrl_props

bind tsc_serial_ctrl tsc_serial_ctrl_props #(.WAKE_CYC(WAKE_CYC)) props_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .conv_power_on(conv_power_on), .conv_start(conv_start),
    .conv_done(conv_done), .full_power_down(full_power_down), .alert_out(alert_out));

/* File: sim/tsc_master_model.sv */
// Bus master model: START, STOP and byte tasks, 48 ns bit time.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/1ps
module tsc_master_model (
    output logic     scl,      // Bus clock, idles high
    output logic     sda_low,  // Master pulls data low
    input wire logic sda       // Resolved data wire
);
    // ==========================================
    // Bit sequences; SCL stands high between frames
    initial scl = 1'b1;
    initial sda_low = 1'b0;
    task automatic bit_x(input logic o, output logic i);
        sda_low = !o;          // Change only in low phase
        #12 scl = 1'b1;
        #12 i = sda;
        #12 scl = 1'b0;
        #12;
    endtask : bit_x
    task automatic start;
        sda_low = 1'b0;
        #12 scl = 1'b1;
        #12 sda_low = 1'b1;
        #12 scl = 1'b0;
        #12;
    endtask : start
    task automatic stop;
        sda_low = 1'b1;
        #12 scl = 1'b1;
        #12 sda_low = 1'b0;
        #12;
    endtask : stop
    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ak, output logic [8:0] rx);
        for (int k = 7; k >= 0; k--) bit_x(tx[k], rx[k+1]);
        bit_x(ak, rx[0]);
    endtask : xfer
endmodule : tsc_master_model

/* File: sim/testbench.sv */
// Self-checking bench for the serial control block.
// Assumes the master model, the bound checker and a 4 ns clock.
`include "tsc_defs.svh"
`timescale 1ns/1ps
module testbench;
    localparam logic [6:0] DEV = {`TSC_ADDR_HI, 3'h2};
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       cdone = 1'b0;
    logic [9:0] temp_val = 10'h000;
    logic       scl, m_low, sda_oe, alert_oe, pwr, cstart, fpd;
    logic [8:0] r;
    int         n_mismatch = 0, n_compared = 0, cyc = 0, n_pwr = 0, c0;
    logic [7:0] rst_tab [4] = '{8'h00, `TSC_CFG_RST, `TSC_UPPER_RST, `TSC_LOWER_RST};
    logic [17:0] rows [3] = '{{2'h1, 8'h1C, 8'h10}, {2'h2, 8'h10, 8'h10}, {2'h3, 8'h05, 8'h05}};
    wire        sda = !(m_low || sda_oe); // Pull-up
    always #2 sys_clk = ~sys_clk;
    tsc_master_model mst_u (.scl(scl), .sda_low(m_low), .sda(sda));
    tsc_serial_ctrl #(.PERIOD_CYC(2000), .WAKE_CYC(10)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .address_select_pin_low(1'b0), .address_select_pin_high(1'b1),
        .alert_out(), .alert_oe(alert_oe), .conv_power_on(pwr), .conv_start(cstart),
        .conv_done(cdone), .conv_result(temp_val), .full_power_down(fpd));
    // Converter stand-in; slow enough that results land after STOP
    always @(posedge cstart) begin
        repeat (100) @(negedge sys_clk);
        cdone = 1'b1;
        @(negedge sys_clk) cdone = 1'b0;
    end
    always @(posedge pwr) n_pwr++;
    always @(posedge sys_clk) if (++cyc == 40000) begin
        n_mismatch++;
        results();
    end
    // ==========================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] p, input logic [7:0] d, input bit two);
        mst_u.start();
        mst_u.xfer({DEV, 1'b0}, 1'b1, r);
        mst_u.xfer({6'h0, p}, 1'b1, r);
        if (two) mst_u.xfer(d, 1'b1, r);
        mst_u.stop();
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic nak);
        mst_u.start();
        mst_u.xfer({a, 1'b1}, 1'b1, r);
        chk({7'h0, r[0]}, {7'h0, nak});
        mst_u.xfer(8'hFF, 1'b1, r);
        if (!nak) chk(r[8:1], e);
        mst_u.stop();
    endtask : rd
    task automatic rdt(input logic [7:0] ea, input logic [7:0] eb);
        wr(2'h0, 8'h00, 1'b0);
        mst_u.start();
        mst_u.xfer({DEV, 1'b1}, 1'b1, r);
        mst_u.xfer(8'hFF, 1'b0, r);
        chk(r[8:1], ea);
        mst_u.xfer(8'hFF, 1'b1, r);
        chk(r[8:1], eb);
        mst_u.stop();
    endtask : rdt
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // ==========================================
    // Sequence
    initial begin
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        rd(DEV, 8'h00, 1'b0);
        for (int k = 1; k < 4; k++) begin
            wr(2'(k), 8'hEE, 1'b0);
            rd(DEV, rst_tab[k], 1'b0);
        end
        for (int k = 0; k < 3; k++) begin
            wr(rows[k][17:16], rows[k][15:8], 1'b1);
            rd(DEV, rows[k][7:0], 1'b0);
        end
        temp_val = 10'h0C8;
        wr(2'h1, 8'h14, 1'b1);
        repeat (300) @(negedge sys_clk);
        rdt(8'h32, 8'h38);
        rdt(8'h32, 8'h30);
        chk({7'h0, alert_oe}, 8'h00);
        rd(`TSC_ARA_ADDR, {DEV, 1'b0}, 1'b0);
        rd(7'h4F, 8'h00, 1'b1);
        temp_val = 10'h020;
        wr(2'h1, 8'h18, 1'b1);
        chk({7'h0, alert_oe}, 8'h01);
        rd(`TSC_ARA_ADDR, 8'h00, 1'b1);
        c0 = n_pwr;
        repeat (2100) @(negedge sys_clk);
        chk(8'(n_pwr > c0), 8'h01);
        wr(2'h1, 8'h80, 1'b1);
        chk({7'h0, fpd}, 8'h01);
        c0 = n_pwr;
        repeat (2100) @(negedge sys_clk);
        chk(8'(n_pwr - c0), 8'h00);
        wr(2'h1, 8'h84, 1'b1);
        repeat (300) @(negedge sys_clk);
        chk(8'(n_pwr - c0), 8'h01);
        rdt(8'h08, 8'h10);
        rdt(8'h08, 8'h00);
        // Mid-run reset: power state and pointer back to defaults
        rst_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk({7'h0, fpd}, 8'h00);
        rd(DEV, 8'h00, 1'b0);
        results();
    end
endmodule : testbench
